// ==== src/sfer_unit.v ====
// Single-precision arithmetic unit with overflow, underflow and inexact
// response, reached over an Avalon-MM slave with one wait state.
// Assumes one clock domain; one scalar operation is run at a time.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sfer_map.vh"

module sfer_unit (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        sys_rst_in,
    // Avalon-MM register slave
    input  wire [4:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    // Exception report towards the handler
    output wire        fp_trap_out,
    output wire [7:0]  trap_vector_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_FIN  = 2'h2;

    reg  [15:0] csr_q, csr_d, snap_q;
    reg  [31:0] opa_q, opb_q, res_q, rdata_q;
    reg  [3:0]  op_q;
    reg  [1:0]  state_q;
    reg  [4:0]  cnt_q;
    reg  [26:0] root_q;
    reg  [5:0]  cause_q;
    reg         trap_q, trap_d, wait_q;
    reg  [7:0]  vec_q;

    // Register hit on word address; reused by every write decode
    function reg_hit;
        input [4:0] a;
        input [4:0] off;
        reg_hit = (a[4:2] == off[4:2]);
    endfunction

    // Byte-lane merge of a bus write into a stored word
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                be_merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
        end
    endfunction

    // Unpack to {signed exponent, 24-bit significand}; denormals normalised
    function [35:0] unpack;
        input [31:0] f;
        input        daz;
        reg   [23:0] m;
        reg   [4:0]  lz;
        reg          hit;
        integer      i;
        begin
            m = {1'b0, f[22:0]};
            lz = 5'h00;
            hit = 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                if (!hit && m[i]) hit = 1'b1;
                else if (!hit) lz = lz + 5'h01;
            end
            if (f[30:23] != 8'h00) unpack = {4'h0, f[30:23], 1'b1, f[22:0]};
            else if (daz || !hit) unpack = {12'h800, 24'h000000};
            else unpack = {12'h001 - {7'h00, lz}, m << lz};
        end
    endfunction

    wire        acc_wr = avs_write_in & ~wait_q;
    wire        busy   = (state_q != ST_IDLE);
    wire        daz    = snap_q[`SFER_CSR_DAZ];
    wire [1:0]  rc     = snap_q[`SFER_CSR_RC_LSB +: 2];
    wire [5:0]  mk     = snap_q[`SFER_CSR_MSK_LSB +: 6];
    wire [35:0] ua     = unpack(opa_q, daz);
    wire [35:0] ub     = unpack(opb_q, daz);
    wire [11:0] ea     = ua[35:24];
    wire [11:0] eb     = ub[35:24];
    wire [23:0] ma     = ua[23:0];
    wire [23:0] mb     = ub[23:0];

    // Operand classes
    wire sa     = opa_q[31];
    wire sb     = opb_q[31] ^ (op_q == `SFER_OP_SUB);
    wire sx     = opa_q[31] ^ opb_q[31];
    wire a_max  = &opa_q[30:23];
    wire b_max  = &opb_q[30:23];
    wire a_nan  = a_max & (|opa_q[22:0]);
    wire b_nan  = b_max & (|opb_q[22:0]);
    wire a_inf  = a_max & ~(|opa_q[22:0]);
    wire b_inf  = b_max & ~(|opb_q[22:0]);
    wire a_zero = ~a_max & (ma == 24'h000000);
    wire b_zero = ~b_max & (mb == 24'h000000);
    wire a_den  = (opa_q[30:23] == 8'h00) & (|opa_q[22:0]) & ~daz;
    wire b_den  = (opb_q[30:23] == 8'h00) & (|opb_q[22:0]) & ~daz;
    wire binop  = (op_q >= `SFER_OP_ADD) && (op_q <= `SFER_OP_DIV);
    wire arith  = (op_q >= `SFER_OP_ADD) && (op_q <= `SFER_OP_ROOT);
    wire cvt    = (op_q == `SFER_OP_S2I) || (op_q == `SFER_OP_S2IT);
    wire is_add = (op_q == `SFER_OP_ADD) || (op_q == `SFER_OP_SUB);
    wire is_div = (op_q == `SFER_OP_DIV);
    wire is_rt  = (op_q == `SFER_OP_ROOT);

    // Shared multiplier for the bitwise divide and root search
    wire [26:0] bitv = 27'h0000001 << cnt_q;
    wire [26:0] cand = (state_q == ST_RUN) ? (root_q | bitv) : root_q;
    wire [53:0] prod = is_rt ? ({27'h0, cand} * {27'h0, cand})
                             : ({27'h0, cand} * {30'h0, mb});
    wire [53:0] tgt  = is_rt ? (ea[0] ? {1'b0, ma, 29'h0} : {2'h0, ma, 28'h0})
                             : {4'h0, ma, 26'h0};
    wire        qstk = (prod != tgt);
    wire [47:0] pmul = {24'h0, ma} * {24'h0, mb};

    // Fault-class checks come first and can end the operation
    reg        spec, fi, fd, fz;
    reg [31:0] spec_res;
    always @* begin
        spec = 1'b0;
        fi = 1'b0;
        fz = 1'b0;
        fd = arith & (a_den | (binop & b_den));
        spec_res = `SFER_QNAN_IND;
        if (arith && (a_nan || (binop && b_nan))) begin
            spec = 1'b1;
            fd = 1'b0;
            fi = (a_nan & ~opa_q[22]) | (binop & b_nan & ~opb_q[22]);
            spec_res = a_nan ? (opa_q | `SFER_QBIT) : (opb_q | `SFER_QBIT);
        end else if ((is_add & a_inf & b_inf & (sa ^ sb)) ||
                     ((op_q == `SFER_OP_MUL) & ((a_inf & b_zero) | (a_zero & b_inf))) ||
                     (is_div & ((a_inf & b_inf) | (a_zero & b_zero))) ||
                     (is_rt & sa & ~a_zero)) begin
            spec = 1'b1;
            fi = 1'b1;
        end else if (is_div & b_zero) begin
            spec = 1'b1;
            fz = ~a_inf;
            fd = fd & a_inf;       // Denormal divided by zero reports only Z
            spec_res = {sx, `SFER_INF};
        end else if (is_add & (a_inf | b_inf)) begin
            spec = 1'b1;
            spec_res = {a_inf ? sa : sb, `SFER_INF};
        end else if (arith & (a_inf | ((op_q == `SFER_OP_MUL) & b_inf))) begin
            spec = 1'b1;
            spec_res = {is_rt ? 1'b0 : sx, `SFER_INF};
        end else if (is_div & b_inf) begin
            spec = 1'b1;
            spec_res = {sx, 31'h0};
        end else if (cvt && (a_max || (!ea[11] && ea >= 12'd158 &&
                                       opa_q != `SFER_INT_MIN_F))) begin
            spec = 1'b1;
            fi = 1'b1;
            spec_res = `SFER_INT_IND;
        end
    end

    // Halved root exponent; arithmetic shift keeps the sign of the offset
    wire [11:0] st_t = ea - 12'd178 - {11'h0, ea[0]};

    // Exact intermediate: value = m_x * 2^(e_x - 174), 50-bit magnitude
    reg [11:0] e_x, de, st;
    reg [49:0] m_x, ml, ms;
    reg        sgn, zsgn, a_big;
    reg [5:0]  sh;
    always @* begin
        a_big = ({~ea[11], ea[10:0]} > {~eb[11], eb[10:0]}) | ((ea == eb) & (ma >= mb));
        de = a_big ? (ea - eb) : (eb - ea);
        sh = (|de[11:6]) ? 6'h3F : de[5:0];
        ml = {2'h0, a_big ? ma : mb, 24'h0};
        ms = {2'h0, a_big ? mb : ma, 24'h0};
        st = 12'd173 + {st_t[11], st_t[11:1]};
        sgn = sx;
        zsgn = sx;
        m_x = {22'h0, cand, qstk};
        e_x = ea - eb + 12'd147;
        case (op_q)
            `SFER_OP_ADD, `SFER_OP_SUB: begin
                ms = (ms >> sh) | {49'h0, |(ms & ~({50{1'b1}} << sh))};
                m_x = (sa ^ sb) ? (ml - ms) : (ml + ms);
                e_x = a_big ? ea : eb;
                sgn = a_big ? sa : sb;
                zsgn = (sa == sb) ? sa : (rc == `SFER_RC_DOWN);
            end
            `SFER_OP_MUL: begin
                m_x = {2'h0, pmul};
                e_x = ea + eb - 12'd126;
            end
            `SFER_OP_ROOT: begin
                e_x = st;
                sgn = sa;
                zsgn = sa;
            end
            `SFER_OP_I2S: begin
                m_x = {18'h0, sa ? (32'h0 - opa_q) : opa_q};
                e_x = 12'd174;
                sgn = sa;
                zsgn = 1'b0;
            end
            default: ;
        endcase
    end

    // Normalise so the leading one sits at bit 49
    reg [5:0]  p;
    integer    j;
    always @* begin
        p = 6'h00;
        for (j = 0; j < 50; j = j + 1)
            if (m_x[j]) p = j[5:0];
    end
    wire [49:0] mn   = m_x << (6'd49 - p);
    wire [11:0] ue   = e_x + {6'h0, p} - 12'd47;
    wire [11:0] db   = 12'd1 - ue;
    wire [6:0]  shb  = (|db[11:7]) ? 7'h7F : db[6:0];
    wire [11:0] dc   = 12'd150 - ea;
    wire [6:0]  shc  = dc[11] ? 7'h00 : ((|dc[10:7]) ? 7'h7F : dc[6:0]);
    wire [1:0]  rci  = (op_q == `SFER_OP_S2IT) ? `SFER_RC_ZERO : rc;
    wire [24:0] r24, rb, ri;
    wire        inx24, inxb, inxi;

    // Unbounded-exponent rounding to 24 bits
    sfer_rnd u_rnd_unb (
        .val_in      (mn),
        .shift_in    (7'h00),
        .mode_in     (rc),
        .sign_in     (sgn),
        .rnd_out     (r24),
        .inexact_out (inx24)
    );

    // Bounded rounding of a tiny value straight from the wide form
    sfer_rnd u_rnd_bnd (
        .val_in      (mn),
        .shift_in    (shb),
        .mode_in     (rc),
        .sign_in     (sgn),
        .rnd_out     (rb),
        .inexact_out (inxb)
    );

    // Float to integer rounding at the binary point
    sfer_rnd u_rnd_int (
        .val_in      ({ma, 26'h0}),
        .shift_in    (shc),
        .mode_in     (rci),
        .sign_in     (sa),
        .rnd_out     (ri),
        .inexact_out (inxi)
    );

    wire [11:0] ue_r  = ue + {11'h0, r24[24]};
    wire        huge  = ~ue_r[11] & (ue_r > `SFER_EMAX);
    wire        tiny  = ue_r[11] | (ue_r == 12'h000);
    wire [11:0] lsh   = ea - 12'd150;
    wire [31:0] mag   = dc[11] ? ({8'h0, ma} << lsh[3:0]) : {7'h0, ri};
    wire        ovinf = (rc == `SFER_RC_NEAR) | ((rc == `SFER_RC_DOWN) & sgn) |
                        ((rc == `SFER_RC_UP) & ~sgn);

    // Exponent re-biased by 192 for the trap handler; the result keeps only its low 8 bits
    wire [11:0] e_ovs = ue_r - `SFER_SCALE;
    wire [11:0] e_uns = ue_r + `SFER_SCALE;

    // Response selection: faults, then overflow, underflow and inexact
    reg [31:0] res_n;
    reg [5:0]  fl_n;
    reg        trap_n, pre;
    always @* begin
        res_n = res_q;
        fl_n = {3'h0, fz, fd, fi};
        trap_n = 1'b0;
        pre = 1'b0;
        if ((fi & ~mk[`SFER_F_INV]) | (fd & ~mk[`SFER_F_DEN]) |
            (fz & ~mk[`SFER_F_ZDIV])) begin
            trap_n = 1'b1;
        end else if (spec) begin
            res_n = spec_res;
        end else if (cvt) begin
            res_n = sa ? (32'h0 - mag) : mag;
            pre = dc[11] ? 1'b0 : inxi;
        end else if (m_x == 50'h0) begin
            res_n = {zsgn, 31'h0};
        end else if (huge && !mk[`SFER_F_OVF]) begin
            res_n = {sgn, e_ovs[7:0], r24[22:0]};
            fl_n[`SFER_F_OVF] = 1'b1;
            fl_n[`SFER_F_PRE] = inx24;
            trap_n = 1'b1;
        end else if (huge) begin
            res_n = {sgn, ovinf ? `SFER_INF : `SFER_MAXF};
            fl_n[`SFER_F_OVF] = 1'b1;
            pre = 1'b1;
        end else if (tiny && !mk[`SFER_F_UNF]) begin
            res_n = {sgn, e_uns[7:0], r24[22:0]};
            fl_n[`SFER_F_UNF] = 1'b1;
            fl_n[`SFER_F_PRE] = inx24;
            trap_n = 1'b1;
        end else if (tiny && snap_q[`SFER_CSR_FTZ]) begin
            res_n = {sgn, 31'h0};
            fl_n[`SFER_F_UNF] = 1'b1;
            pre = 1'b1;
        end else if (tiny) begin
            res_n = {sgn, 7'h00, rb[23:0]};
            fl_n[`SFER_F_UNF] = inxb;
            pre = inxb;
        end else begin
            res_n = {sgn, ue_r[7:0], r24[22:0]};
            pre = inx24;
        end
        // Inexact traps only once no unmasked O/U has claimed the op
        if (pre) begin
            fl_n[`SFER_F_PRE] = 1'b1;
            trap_n = ~mk[`SFER_F_PRE];
        end
    end

    // Bus write merged into the control word; only the low half exists
    wire [31:0] csr_wr = be_merge({16'h0, csr_q}, avs_writedata_in, avs_byteenable_in);

    // Control register and trap flag next values; hardware set wins
    always @* begin
        csr_d = csr_q;
        trap_d = trap_q;
        if (acc_wr && reg_hit(avs_address_in, `SFER_OFF_CSR))
            csr_d = csr_wr[15:0] & `SFER_CSR_WMASK;
        if (acc_wr && reg_hit(avs_address_in, `SFER_OFF_STAT) &&
            avs_byteenable_in[0] && avs_writedata_in[`SFER_ST_TRAP])
            trap_d = 1'b0;
        if (state_q == ST_FIN) begin
            csr_d[5:0] = csr_d[5:0] | fl_n;
            trap_d = trap_d | trap_n;
        end
    end

    // Read multiplexer
    reg [31:0] rd_mux;
    always @* begin
        case (avs_address_in[4:2])
            3'h0:    rd_mux = {16'h0, csr_q};
            3'h1:    rd_mux = opa_q;
            3'h2:    rd_mux = opb_q;
            3'h3:    rd_mux = {28'h0, op_q};
            3'h4:    rd_mux = res_q;
            3'h5:    rd_mux = {8'h0, vec_q, 2'h0, cause_q, 6'h00, trap_q, busy};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Bus handshake, registers and the operation sequencer
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            csr_q <= `SFER_CSR_RESET;
            snap_q <= `SFER_CSR_RESET;
            opa_q <= 32'h00000000;
            opb_q <= 32'h00000000;
            res_q <= 32'h00000000;
            op_q <= 4'h0;
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            root_q <= 27'h0000000;
            cause_q <= 6'h00;
            trap_q <= 1'b0;
            vec_q <= 8'h00;
        end else begin
            // One wait state: low for one cycle after a request is seen
            wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
            if (avs_read_in & wait_q)
                rdata_q <= rd_mux;
            csr_q <= csr_d;
            trap_q <= trap_d;
            // Operands are locked while an operation is in flight
            if (acc_wr && !busy && reg_hit(avs_address_in, `SFER_OFF_OPA))
                opa_q <= be_merge(opa_q, avs_writedata_in, avs_byteenable_in);
            if (acc_wr && !busy && reg_hit(avs_address_in, `SFER_OFF_OPB))
                opb_q <= be_merge(opb_q, avs_writedata_in, avs_byteenable_in);
            case (state_q)
                ST_IDLE: begin
                    if (acc_wr && reg_hit(avs_address_in, `SFER_OFF_CMD) &&
                        avs_byteenable_in[0] && avs_writedata_in[3:0] != 4'h0 &&
                        avs_writedata_in[3:0] <= `SFER_OP_S2IT) begin
                        op_q <= avs_writedata_in[3:0];
                        snap_q <= csr_q;
                        cnt_q <= `SFER_ITER;
                        root_q <= 27'h0000000;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (prod <= tgt)
                        root_q <= cand;
                    cnt_q <= cnt_q - 5'h01;
                    if (cnt_q == 5'h00)
                        state_q <= ST_FIN;
                end
                ST_FIN: begin
                    res_q <= res_n;
                    cause_q <= fl_n;
                    if (trap_n)
                        vec_q <= `SFER_VECTOR;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign fp_trap_out         = trap_q;
    assign trap_vector_out     = vec_q;
endmodule // sfer_unit

`default_nettype wire

// ==== src/sfer_map.vh ====
// Constants for the single-precision exception response unit: register
// offsets, control field positions, operation codes and encodings.
// Included by every design file of the unit; holds definitions only.
`ifndef SFER_MAP_VH
`define SFER_MAP_VH

// Register byte offsets, one aligned 32-bit word each
`define SFER_OFF_CSR      5'h00
`define SFER_OFF_OPA      5'h04
`define SFER_OFF_OPB      5'h08
`define SFER_OFF_CMD      5'h0C
`define SFER_OFF_RES      5'h10
`define SFER_OFF_STAT     5'h14

// Control and status fields: flags [5:0], masks [12:7]
`define SFER_CSR_DAZ      6
`define SFER_CSR_MSK_LSB  7
`define SFER_CSR_RC_LSB   13
`define SFER_CSR_FTZ      15
`define SFER_CSR_RESET    16'h1F80
`define SFER_CSR_WMASK    16'hFFFF

// Exception flag and mask bit positions
`define SFER_F_INV        0
`define SFER_F_DEN        1
`define SFER_F_ZDIV       2
`define SFER_F_OVF        3
`define SFER_F_UNF        4
`define SFER_F_PRE        5

// Status word fields
`define SFER_ST_BUSY      0
`define SFER_ST_TRAP      1
`define SFER_ST_CAUSE_LSB 8
`define SFER_ST_VEC_LSB   16

// Operation codes
`define SFER_OP_ADD       4'h1
`define SFER_OP_SUB       4'h2
`define SFER_OP_MUL       4'h3
`define SFER_OP_DIV       4'h4
`define SFER_OP_ROOT      4'h5
`define SFER_OP_I2S       4'h6
`define SFER_OP_S2I       4'h7
`define SFER_OP_S2IT      4'h8

// Rounding control encodings
`define SFER_RC_NEAR      2'h0
`define SFER_RC_DOWN      2'h1
`define SFER_RC_UP        2'h2
`define SFER_RC_ZERO      2'h3

// Numeric constants
`define SFER_VECTOR       8'h13
`define SFER_SCALE        12'h0C0
`define SFER_EMAX         12'h0FE
`define SFER_QBIT         32'h00400000
`define SFER_QNAN_IND     32'hFFC00000
`define SFER_INT_IND      32'h80000000
`define SFER_INT_MIN_F    32'hCF000000
`define SFER_INF          31'h7F800000
`define SFER_MAXF         31'h7F7FFFFF
`define SFER_ITER         5'h1A

`endif

// ==== src/sfer_rnd.v ====
// Rounds a wide magnitude once at a chosen position: shifts right by
// shift_in, keeps 24 bits and rounds by the selected mode.
// Purely combinational; the instantiating unit registers the outcome.
`timescale 1ns/1ps
`default_nettype none
`include "sfer_map.vh"

module sfer_rnd (
    // Value and rounding position
    input  wire [49:0] val_in,
    input  wire [6:0]  shift_in,
    input  wire [1:0]  mode_in,
    input  wire        sign_in,
    // Rounded 24-bit field plus carry, and lost-bits indication
    output reg  [24:0] rnd_out,
    output reg         inexact_out
);
    reg [49:0] sv;
    reg        grd;
    reg        stk;
    reg        inc;

    // One rounding from the full-width value, never from a rounded one
    always @* begin
        sv = val_in >> shift_in;
        grd = sv[25];
        stk = (|sv[24:0]) | (|(val_in & ~({50{1'b1}} << shift_in)));
        case (mode_in)
            `SFER_RC_NEAR: inc = grd & (stk | sv[26]);
            `SFER_RC_DOWN: inc = sign_in & (grd | stk);
            `SFER_RC_UP:   inc = ~sign_in & (grd | stk);
            default:       inc = 1'b0;
        endcase
        rnd_out = {1'b0, sv[49:26]} + {24'h000000, inc};
        inexact_out = grd | stk;
    end
endmodule // sfer_rnd

`default_nettype wire

// ==== verification/sfer_unit_assertions.sv ====
// Checker for the exception unit: bus handshake and trap report timing.
// Sees only the ports of sfer_unit and is attached by bind below.
`timescale 1ns/1ps
`default_nettype none
module sfer_unit_assertions (
    // Clock and reset
    input wire        mclk_in,
    input wire        sys_rst_in,
    // Register bus
    input wire [4:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0]  avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    // Trap report
    input wire        fp_trap_out,
    input wire [7:0]  trap_vector_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // A request answered by exactly one low cycle of waitrequest
    sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
    sequence s_ack; !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("waitrequest not low for one cycle");
    property p_cause; $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_vec; fp_trap_out |-> trap_vector_out == 8'h13; endproperty
    a_vec: assert property (p_vec) else $error("trap without vector 19");
    property p_sticky; trap_vector_out != 8'h00 |=> trap_vector_out == 8'h13; endproperty
    a_sticky: assert property (p_sticky) else $error("vector changed");
    // Trap leaves only through a status write
    property p_w1c; $fell(fp_trap_out) |-> $past(avs_write_in && avs_address_in[4:2] == 3'h5);
    endproperty
    a_w1c: assert property (p_w1c) else $error("trap cleared without write");
    // Trap rises 28 edges after the command write takes effect
    property p_late; $rose(fp_trap_out) |->
        $past(avs_write_in && !avs_waitrequest_out && avs_address_in[4:2] == 3'h3, 29);
    endproperty
    a_late: assert property (p_late) else $error("trap at wrong time");
    property p_unmap; avs_read_in && avs_waitrequest_out && avs_address_in[4:3] == 2'b11
        |=> avs_readdata_out == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule // sfer_unit_assertions
bind sfer_unit sfer_unit_assertions u_sfer_unit_assertions (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .fp_trap_out(fp_trap_out),
    .trap_vector_out(trap_vector_out));
`default_nettype wire

// ==== verification/sfer_unit_tb_top.sv ====
// Testbench for the exception unit: register tasks and an operation table.
// Drives the Avalon-MM slave itself; one clock, no partner model.
`timescale 1ns/1ps
`default_nettype none
`include "sfer_map.vh"
module sfer_unit_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        waitreq;
    logic        trap;
    logic [7:0]  vec;
    logic [31:0] q;
    integer      err_total = 0;
    integer      check_count = 0;
    // Overflow substitutes, index is rounding mode times two plus sign
    logic [31:0] ovf_res [0:7] = '{32'h7F800000, 32'hFF800000, 32'h7F7FFFFF, 32'hFF800000,
                                   32'h7F800000, 32'hFF7FFFFF, 32'h7F7FFFFF, 32'hFF7FFFFF};
    // 200 MHz clock
    always #2.5 clk = ~clk;
    sfer_unit u_sfer_unit (.mclk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq),
        .fp_trap_out(trap), .trap_vector_out(vec));
    task stop_test;
        begin
            $display("mismatches %0d of %0d checks", err_total, check_count);
            if (err_total == 0 && check_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One access; request held until waitrequest is sampled low, bounded
    task bus(input w, input [4:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            addr <= a;
            wdat <= d;
            wr <= w;
            rd <= !w;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (waitreq !== 1'b0 && n < 20);
            q = rdat;
            wr <= 1'b0;
            rd <= 1'b0;
            if (waitreq !== 1'b0) begin
                err_total = err_total + 1;
                stop_test;
            end
        end
    endtask
    // Runs one operation; trap expected when a raised flag is unmasked
    task t_op(input [15:0] csr, input [31:0] a, input [31:0] b, input [3:0] op,
              input [31:0] res, input [5:0] cause);
        integer n;
        logic   tr;
        begin
            tr = |(cause & ~csr[12:7]);
            bus(1'b1, `SFER_OFF_CSR, {16'h0, csr});
            bus(1'b1, `SFER_OFF_OPA, a);
            bus(1'b1, `SFER_OFF_OPB, b);
            bus(1'b1, `SFER_OFF_CMD, {28'h0, op});
            n = 0;
            do begin
                bus(1'b0, `SFER_OFF_STAT, 32'h0);
                n = n + 1;
            end while (q[0] !== 1'b0 && n < 40);
            if (q[0] !== 1'b0) begin
                err_total = err_total + 1;
                stop_test;
            end
            check(q & 32'h00003F02, {18'h0, cause, 6'h0, tr, 1'b0});
            check({31'h0, trap}, {31'h0, tr});
            bus(1'b0, `SFER_OFF_RES, 32'h0);
            check(q, res);
            bus(1'b0, `SFER_OFF_CSR, 32'h0);
            check(q, {16'h0, csr[15:6], cause});
            if (tr) begin
                check({24'h0, vec}, 32'h00000013);
                bus(1'b1, `SFER_OFF_STAT, 32'h2);
                bus(1'b0, `SFER_OFF_STAT, 32'h0);
                check({31'h0, trap}, 32'h0);
            end
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `SFER_OFF_CSR, 32'h0);
        check(q, 32'h00001F80);
        check({24'h0, vec}, 32'h0);
        bus(1'b1, 5'h18, 32'hFFFFFFFF);
        bus(1'b0, 5'h18, 32'h0);
        check(q, 32'h0);
        // Masked overflow in every rounding mode and sign
        for (int i = 0; i < 8; i++)
            t_op({1'b0, 2'(i / 2), 13'h1F80}, 32'h7F000000, i[0] ? 32'hC0000000 : 32'h40000000,
                 `SFER_OP_MUL, ovf_res[i], 6'h28);
        t_op(16'h1B80, 32'h7F000000, 32'h40000000, `SFER_OP_MUL, 32'h1F800000, 6'h08);
        t_op(16'h1F80, 32'h00800001, 32'h3F000000, `SFER_OP_MUL, 32'h00400000, 6'h30);
        t_op(16'h1F80, 32'h00800000, 32'h3F000000, `SFER_OP_MUL, 32'h00400000, 6'h00);
        t_op(16'h1780, 32'h00800000, 32'h3F000000, `SFER_OP_MUL, 32'h60000000, 6'h10);
        t_op(16'h9F80, 32'h80800001, 32'h3F000000, `SFER_OP_MUL,
             32'h80000000, 6'h30);
        t_op(16'h1FC0, 32'h00000001, 32'h3F800000, `SFER_OP_ADD,
             32'h3F800000, 6'h00);
        t_op(16'h1F80, 32'h3F800000, 32'h33800000, `SFER_OP_ADD, 32'h3F800000, 6'h20);
        t_op(16'h5F80, 32'h3F800000, 32'h33800000, `SFER_OP_ADD,
             32'h3F800001, 6'h20);
        t_op(16'h0F80, 32'h3F800000, 32'h33800000, `SFER_OP_ADD, 32'h3F800000, 6'h20);
        t_op(16'h0F80, 32'h7F000000, 32'h40000000, `SFER_OP_MUL,
             32'h7F800000, 6'h28);
        t_op(16'h1F80, 32'h3F800000, 32'h40400000, `SFER_OP_DIV, 32'h3EAAAAAB, 6'h20);
        t_op(16'h1F80, 32'h3F800000, 32'h33800000, `SFER_OP_SUB, 32'h3F7FFFFF, 6'h00);
        t_op(16'h1F80, 32'h40000000, 32'h0, `SFER_OP_ROOT, 32'h3FB504F3, 6'h20);
        t_op(16'h1F80, 32'h01000001, 32'h0, `SFER_OP_I2S, 32'h4B800000, 6'h20);
        t_op(16'h1F80, 32'h3FC00000, 32'h0, `SFER_OP_S2I, 32'h00000002, 6'h20);
        t_op(16'h1F80, 32'h3FC00000, 32'h0, `SFER_OP_S2IT, 32'h00000001, 6'h20);
        t_op(16'h1F00, 32'h7F800000, 32'hFF800000, `SFER_OP_ADD,
             32'h00000001, 6'h01);
        stop_test;
    end
endmodule // sfer_unit_tb_top
`default_nettype wire
